/* File: bench/aod_link_props.sv */
`timescale 1ns/1ps
module aod_link_props (
	// Clock and reset
	input wire logic clock_i,
	input wire logic nrst_i,
	// Link signals
	input wire logic [15:0] word,
	input wire logic word_valid,
	input wire logic [4:0] word_len
);
	default clocking @(posedge clock_i); endclocking
	default disable iff (!nrst_i);

	a_len_full: assert property (word_valid |-> word_len == 5'h10)
		else $error("word sent with short length");
	a_spare_low: assert property (word_valid |-> !word[15])
		else $error("spare word bit set");
	a_disable_clean: assert property (
		word_valid && !word[14] |-> word == 16'h0000)
		else $error("disable word carries data");
	// A burst walks the pending channels lowest first
	a_burst_rising: assert property (
		word_valid && word[14] && $past(word_valid) && $past(word[14])
		|-> word[13:12] > $past(word[13:12]))
		else $error("burst channel order broken");
	a_idle_len: assert property (!word_valid |-> word_len == 5'h00)
		else $error("idle link shows a length");
	a_reset_idle: assert property ($rose(nrst_i) |-> !word_valid)
		else $error("word sent at reset release");

	c_burst: cover property (word_valid [*3]);
	c_disable: cover property (word_valid && !word[14]);
	c_last_chan: cover property (word_valid && word[13:12] == 2'h3);
endmodule

/* File: bench/testbench.sv */
`timescale 1ns/1ps
module testbench;
	logic clock_i, nrst_i, wr_i, rd_i, en_a, drop_b, seen_drop;
	logic [2:0] addr_i;
	logic [15:0] wdata_i, rdata_o;
	logic [3:0][11:0] data_a, data_b;
	logic [3:0][14:0] cur_a;
	logic taken_a;
	logic [3:0] live_a, upd_a, upd_seen;
	int n_mismatch, n_checks, n_taken;
	aod_link_if link_a();
	aod_link_if link_b();
	aod_host i_aod_host(.clock_i(clock_i), .nrst_i(nrst_i),
		.addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
		.rdata_o(rdata_o), .link(link_a));
	aod_device i_aod_device(.clock_i(clock_i), .nrst_i(nrst_i),
		.link(link_a), .outputs_enabled_o(en_a), .chan_live_o(live_a),
		.chan_data_o(data_a), .chan_current_ua_o(cur_a),
		.word_taken_o(taken_a), .word_dropped_o(),
		.chan_updated_o(upd_a));
	// Second device faces the bench so that broken words can be sent
	aod_device i_aod_device_b(.clock_i(clock_i), .nrst_i(nrst_i),
		.link(link_b), .outputs_enabled_o(), .chan_live_o(),
		.chan_data_o(data_b), .chan_current_ua_o(), .word_taken_o(),
		.word_dropped_o(drop_b), .chan_updated_o());
	aod_link_props i_aod_link_props(.clock_i(clock_i), .nrst_i(nrst_i),
		.word(link_a.word), .word_valid(link_a.word_valid),
		.word_len(link_a.word_len));

	initial begin
		clock_i = 1'b0;
		forever #10 clock_i = ~clock_i;
	end
	always @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			seen_drop <= 1'b0;
			upd_seen <= 4'h0;
			n_taken <= 0;
		end else begin
			if (drop_b === 1'b1) seen_drop <= 1'b1;
			upd_seen <= upd_seen | upd_a;
			if (taken_a === 1'b1) n_taken <= n_taken + 1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	function automatic logic [15:0] ua(input logic [11:0] d);
		return 16'(32'h0FA0 + 32'(d) * 32'h3E80 / 32'h0FFF);
	endfunction
	task automatic chk(input string nm, input logic [15:0] e, g);
		n_checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic chk_ch(input logic [3:0][11:0] e);
		for (int i = 0; i < 4; i++) begin
			chk("chan data", {4'h0, e[i]}, {4'h0, data_a[i]});
			chk("chan current", ua(e[i]), {1'b0, cur_a[i]});
		end
	endtask
	task automatic wr(input logic [2:0] a, input logic [15:0] d);
		@(posedge clock_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge clock_i);
		wr_i <= 1'b0;
	endtask
	task automatic rd(input logic [2:0] a, input logic [15:0] e, string nm);
		@(posedge clock_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge clock_i);
		rd_i <= 1'b0;
		#1;
		chk(nm, e, rdata_o);
	endtask
	task automatic send_b(input logic [15:0] w, input logic [4:0] n);
		@(posedge clock_i);
		link_b.word <= w;
		link_b.word_len <= n;
		link_b.word_valid <= 1'b1;
		@(posedge clock_i);
		link_b.word_valid <= 1'b0;
		link_b.word <= ~w;
	endtask
	task automatic settle;
		repeat (12) @(posedge clock_i);
		#1;
	endtask
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////
	initial begin
		nrst_i = 1'b0;
		{wr_i, rd_i, addr_i, wdata_i} = '0;
		link_b.word = 16'h0000;
		link_b.word_len = 5'h00;
		link_b.word_valid = 1'b0;
		repeat (20) @(posedge clock_i);
		nrst_i <= 1'b1;
		settle();
		chk("enabled", 16'h0000, {15'h0, en_a});
		chk_ch('0);
		rd(3'h7, 16'h0000, "unmapped");
		$display("test reset done");
		wr(3'h0, 16'h0001);
		wr(3'h1, 16'hF123);
		rd(3'h1, 16'h0123, "sample1");
		wr(3'h5, 16'h0001);
		settle();
		chk("enabled", 16'h0001, {15'h0, en_a});
		chk_ch({12'h000, 12'h000, 12'h000, 12'h123});
		chk("updated", 16'h0001, {12'h000, upd_seen});
		chk("live", 16'h0001, {12'h000, live_a});
		chk("taken", 16'h0001, 16'(n_taken));
		$display("test one channel done");
		wr(3'h2, 16'h0FFF);
		wr(3'h3, 16'h0800);
		wr(3'h4, 16'h07FF);
		// Three back-to-back words, channel one must hold
		wr(3'h5, 16'h000E);
		settle();
		chk_ch({12'h7FF, 12'h800, 12'hFFF, 12'h123});
		chk("updated", 16'h000F, {12'h000, upd_seen});
		chk("live", 16'h000F, {12'h000, live_a});
		chk("taken", 16'h0004, 16'(n_taken));
		rd(3'h6, 16'h0400, "status");
		$display("test burst done");
		wr(3'h0, 16'h0000);
		settle();
		chk("enabled", 16'h0000, {15'h0, en_a});
		chk("live", 16'h0000, {12'h000, live_a});
		chk("taken", 16'h0005, 16'(n_taken));
		rd(3'h6, 16'h0500, "status");
		chk_ch('0);
		wr(3'h0, 16'h0001);
		settle();
		chk_ch('0);
		$display("test disable done");
		send_b(16'h5456, 5'h0F);
		settle();
		chk("dropped", 16'h0001, {15'h0, seen_drop});
		chk("short word", 16'h0000, {4'h0, data_b[1]});
		send_b(16'hF789, 5'h10);
		settle();
		chk("spare bit", 16'h0789, {4'h0, data_b[3]});
		$display("test link faults done");
		print_verdict();
	end
	initial begin
		repeat (3000) @(posedge clock_i);
		n_mismatch++;
		print_verdict();
	end
endmodule

/* File: src/aod_device.sv */
`timescale 1ns/1ps
// Summary of operation
// R01 - Select bits pick channel one to four
// R02 - Enable bit gates all four channels
// R03 - Sample written only into selected channel
// R04 - Low twelve bits sample, top four control
// R05 - Words with fewer than sixteen bits dropped
// R06 - Current is 4 mA plus 16D/4095 mA
// R07 - Back-to-back words each update their channel
// R08 - Disable clears data, drives 4 mA
// R09 - Bit fifteen of word is ignored
// R10 - Unselected channels hold their stored sample
module aod_device (
	// Clock and reset
	input wire logic clock_i,
	input wire logic nrst_i,
	// Word link from the controller
	aod_link_if.dev link,
	// Channel state
	output logic outputs_enabled_o,
	output logic [3:0] chan_live_o,
	output logic [3:0][11:0] chan_data_o,
	// Analog drive, in microamps
	output logic [3:0][14:0] chan_current_ua_o,
	// Event pulses
	output logic word_taken_o,
	output logic word_dropped_o,
	output logic [3:0] chan_updated_o
);

	////////////////////////////////////////////////////////////////////
	// Word decode

	logic take;
	logic drop;
	logic en_bit;
	logic [1:0] sel;
	logic [11:0] sample;
	logic [3:0] sel_hot;

	// A transfer counts only when every bit of the word arrived
	function automatic logic full_word(input logic [4:0] len);
		return len == aod_pkg::FULL_LEN;
	endfunction

	// Partial immediate transfers never touch the channels; a length
	// above sixteen is just as torn and is dropped the same way
	assign take = link.word_valid && full_word(link.word_len); // R05
	assign drop = link.word_valid && !full_word(link.word_len); // R05

	assign en_bit = link.word[aod_pkg::EN_POS]; // R02
	assign sel = {link.word[aod_pkg::SEL_HI_POS],
		link.word[aod_pkg::SEL_LO_POS]}; // R01
	assign sample = link.word[aod_pkg::SAMPLE_W-1:0]; // R04
	// Bit fifteen is never read anywhere below
	// R09

	// One-hot steer; only the selected register ever sees the sample
	always_comb begin
		sel_hot = 4'h0;
		sel_hot[sel] = 1'b1; // R01
	end

	////////////////////////////////////////////////////////////////////
	// Enable state

	logic enabled;

	// Each full word carries the enable bit, so a word with bit fourteen
	// clear is the disable command itself; torn words never move it

	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			enabled <= 1'b0;
		end else if (take) begin
			enabled <= en_bit; // R02
		end
	end

	////////////////////////////////////////////////////////////////////
	// Channel data registers

	logic [3:0][11:0] chan_data;
	logic [3:0] live;

	// Reset leaves each channel as a disable word would, so releasing
	// reset cannot glitch a loop current
	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			for (int i = 0; i < aod_pkg::NUM_CH; i++) begin
				chan_data[i] <= aod_pkg::SAMPLE_RST;
			end
		end else if (take) begin
			for (int i = 0; i < aod_pkg::NUM_CH; i++) begin
				// A disable word stores nothing, not even its own sample
				if (!en_bit) begin
					chan_data[i] <= aod_pkg::SAMPLE_RST; // R08
				end else if (sel_hot[i]) begin
					chan_data[i] <= sample; // R03
				end
				// Other channels keep their sample
				// R10
			end
		end
	end

	// A channel comes back only once enabled and written again
	// Live is sticky per channel, so a burst lights each in turn
	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			live <= 4'h0;
		end else if (take) begin
			if (!en_bit) begin
				live <= 4'h0; // R08
			end else begin
				live <= live | sel_hot; // R07
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// Current conversion

	// Dark or disabled channels sit at the bottom of the loop range;
	// truncating the division keeps the code-to-current map monotonic
	function automatic logic [14:0] loop_ua(input logic on,
		input logic [11:0] d);
		if (on) begin
			return aod_pkg::sample_to_ua(d); // R06
		end
		return aod_pkg::I_MIN_UA; // R08
	endfunction

	// Divider sits one register after the data so it has a full cycle;
	// the loop current thus trails the data register by one clock.
	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			for (int i = 0; i < aod_pkg::NUM_CH; i++) begin
				chan_current_ua_o[i] <= aod_pkg::I_MIN_UA;
			end
		end else begin
			for (int i = 0; i < aod_pkg::NUM_CH; i++) begin
				chan_current_ua_o[i] <= loop_ua(enabled && live[i],
					chan_data[i]); // R06 R08
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// Status outputs

	// Registered copies keep every top output on a flop, at the cost
	// of one clock of lag against the internal state
	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			outputs_enabled_o <= 1'b0;
		end else begin
			outputs_enabled_o <= enabled; // R02
		end
	end

	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			chan_live_o <= 4'h0;
		end else begin
			chan_live_o <= live; // R08
		end
	end

	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			for (int i = 0; i < aod_pkg::NUM_CH; i++) begin
				chan_data_o[i] <= aod_pkg::SAMPLE_RST;
			end
		end else begin
			chan_data_o <= chan_data;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Event pulses

	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			word_taken_o <= 1'b0;
		end else begin
			word_taken_o <= take; // R05
		end
	end

	// A torn word is reported, never applied, so software can retry it
	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			word_dropped_o <= 1'b0;
		end else begin
			word_dropped_o <= drop; // R05
		end
	end

	// Every full word with the enable bit set counts, so four in a row update four;
	// a disable word clears every channel yet pulses none
	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			chan_updated_o <= 4'h0;
		end else if (take && en_bit) begin
			chan_updated_o <= sel_hot; // R07
		end else begin
			chan_updated_o <= 4'h0;
		end
	end

endmodule

/* File: src/aod_host.sv */
`timescale 1ns/1ps
module aod_host (
	// Clock and reset
	input wire logic clock_i,
	input wire logic nrst_i,
	// Register port
	input wire logic [2:0] addr_i,
	input wire logic [15:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [15:0] rdata_o,
	// Word link to the module
	aod_link_if.host link
);

	////////////////////////////////////////////////////////////////////
	// Registers

	logic enable;
	logic [3:0][11:0] samples;
	logic [3:0] pending;
	logic dis_pending;
	logic [7:0] word_cnt;
	aod_pkg::aod_state_e state;
	logic [3:0] sent;
	logic dis_sent;
	logic wr_ctrl;
	logic wr_send;

	assign wr_ctrl = wr_i && (addr_i == aod_pkg::OFF_CTRL);
	assign wr_send = wr_i && (addr_i == aod_pkg::OFF_SEND);

	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			enable <= 1'b0;
		end else if (wr_ctrl) begin
			enable <= wdata_i[aod_pkg::CTRL_EN_POS]; // R02
		end
	end

	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			for (int i = 0; i < aod_pkg::NUM_CH; i++) begin
				samples[i] <= aod_pkg::SAMPLE_RST;
			end
		end else begin
			for (int i = 0; i < aod_pkg::NUM_CH; i++) begin
				if (wr_i && addr_i == 3'(aod_pkg::OFF_SAMPLE1 + 3'(i))) begin
					samples[i] <= wdata_i[11:0]; // R04
				end
			end
		end
	end

	// A request that lands with its own send wins over the clear
	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			pending <= 4'h0;
			dis_pending <= 1'b0;
		end else begin
			pending <= (pending & ~sent) | (wr_send ? wdata_i[3:0] : 4'h0);
			dis_pending <= (dis_pending && !dis_sent) ||
				(wr_ctrl && enable && !wdata_i[aod_pkg::CTRL_EN_POS]);
		end
	end

	////////////////////////////////////////////////////////////////////
	// Word sender

	logic [1:0] pick;
	logic [15:0] next_word;

	always_comb begin
		pick = 2'h0;
		for (int i = aod_pkg::NUM_CH - 1; i >= 0; i--) begin
			if (pending[i]) begin
				pick = 2'(i);
			end
		end
		next_word = {1'b0, enable, pick,
			12'(16'(samples[pick]) & aod_pkg::SAMPLE_MASK)}; // R01 R04
	end

	// Disable goes first; then one full word per cycle, lowest channel
	always_comb begin
		sent = 4'h0;
		dis_sent = 1'b0;
		if (state == aod_pkg::AOD_SEND) begin
			if (dis_pending) begin
				dis_sent = 1'b1;
			end else if (pending != 4'h0) begin
				sent[pick] = 1'b1; // R07
			end
		end
	end

	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			state <= aod_pkg::AOD_IDLE;
		end else begin
			case (state)
				aod_pkg::AOD_IDLE: begin
					if (pending != 4'h0 || dis_pending) begin
						state <= aod_pkg::AOD_SEND;
					end
				end
				aod_pkg::AOD_SEND: begin
					if ((pending & ~sent) == 4'h0 && !wr_send) begin
						state <= aod_pkg::AOD_IDLE;
					end
				end
				default: begin
					state <= aod_pkg::AOD_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			link.word <= aod_pkg::WORD_RST;
			link.word_valid <= 1'b0;
			link.word_len <= 5'h00;
			word_cnt <= aod_pkg::CNT_RST;
		end else if (dis_sent) begin
			link.word <= aod_pkg::WORD_RST; // R08
			link.word_valid <= 1'b1;
			link.word_len <= aod_pkg::FULL_LEN; // R05
			word_cnt <= word_cnt + 8'h01;
		end else if (sent != 4'h0) begin
			link.word <= next_word; // R03
			link.word_valid <= 1'b1;
			link.word_len <= aod_pkg::FULL_LEN; // R05
			word_cnt <= word_cnt + 8'h01;
		end else begin
			link.word_valid <= 1'b0;
			link.word_len <= 5'h00;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Read port

	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rdata_o <= 16'h0000;
		end else if (rd_i) begin
			case (addr_i)
				aod_pkg::OFF_CTRL: rdata_o <= {15'h0, enable};
				3'h1, 3'h2, 3'h3, 3'h4: begin
					rdata_o <= {4'h0, samples[2'(addr_i - 3'h1)]};
				end
				aod_pkg::OFF_STATUS: begin
					rdata_o <= {word_cnt, pending, 3'h0,
						state == aod_pkg::AOD_SEND};
				end
				default: rdata_o <= 16'h0000;
			endcase
		end else begin
			rdata_o <= 16'h0000;
		end
	end

endmodule

/* File: src/aod_link_if.sv */
`timescale 1ns/1ps
interface aod_link_if;
	logic [15:0] word;
	logic word_valid;
	logic [4:0] word_len;

	modport dev (
		input word,
		input word_valid,
		input word_len
	);

	modport host (
		output word,
		output word_valid,
		output word_len
	);
endinterface

/* File: src/aod_pkg.sv */
package aod_pkg;

	// Output word layout
	localparam int WORD_W = 16;
	localparam int SAMPLE_W = 12;
	localparam int NUM_CH = 4;
	localparam int SEL_LO_POS = 12;
	localparam int SEL_HI_POS = 13;
	localparam int EN_POS = 14;
	localparam int UNUSED_POS = 15;
	localparam logic [15:0] SAMPLE_MASK = 16'h0FFF;
	localparam logic [4:0] FULL_LEN = 5'h10;

	// Current scale in microamps
	localparam int CUR_W = 15;
	localparam logic [14:0] I_MIN_UA = 15'hFA0;
	localparam logic [25:0] I_SPAN_UA = 26'h3E80;
	localparam logic [25:0] FULL_SCALE = 26'hFFF;

	// Controller register offsets
	localparam int ADDR_W = 3;
	localparam logic [2:0] OFF_CTRL = 3'h0;
	localparam logic [2:0] OFF_SAMPLE1 = 3'h1;
	localparam logic [2:0] OFF_SEND = 3'h5;
	localparam logic [2:0] OFF_STATUS = 3'h6;
	localparam int CTRL_EN_POS = 0;
	localparam int STAT_BUSY_POS = 0;
	localparam int STAT_PEND_POS = 4;
	localparam int STAT_CNT_POS = 8;

	// Reset values
	localparam logic [11:0] SAMPLE_RST = 12'h000;
	localparam logic [15:0] WORD_RST = 16'h0000;
	localparam logic [7:0] CNT_RST = 8'h00;

	typedef enum logic [0:0] {
		AOD_IDLE = 1'b0,
		AOD_SEND = 1'b1
	} aod_state_e;

	// Sample code to loop current, 4 mA at zero, 20 mA at full scale
	function automatic logic [14:0] sample_to_ua(input logic [11:0] d);
		logic [25:0] prod;
		logic [25:0] quot;
		prod = 26'(d) * I_SPAN_UA;
		quot = prod / FULL_SCALE;
		return I_MIN_UA + quot[14:0];
	endfunction

endpackage
